//--- rtl/rfc_pkg.sv
// Constants, types and helpers for the reconciliation fault control block.
// Assumes a 64-bit, 8-lane data path toward the MAC and the PCS, one clock.
package rfc_pkg;

    // Register byte offsets
    localparam logic [7:0] RFC_CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] RFC_STATUS_OFFSET = 8'h04;

    // Control register fields
    localparam int         RFC_CTRL_FAULT_EN_BIT = 0;
    localparam int         RFC_CTRL_LOCAL_BIT    = 1;
    localparam int         RFC_CTRL_REMOTE_BIT   = 2;
    localparam int         RFC_CTRL_IDLE_BIT     = 3;
    localparam logic [3:0] RFC_CTRL_RESET        = 4'h0;

    // Status register fields
    localparam int RFC_STAT_RX_LOCAL_BIT  = 0;
    localparam int RFC_STAT_RX_REMOTE_BIT = 1;
    localparam int RFC_STAT_TX_MODE_LSB   = 4;

    // AHB-Lite transfer type: bit 1 set for NONSEQ or SEQ
    localparam int RFC_HTRANS_ACTIVE_BIT = 1;

    // Lane characters and control patterns
    localparam logic [7:0]  RFC_CHAR_IDLE    = 8'h07;
    localparam logic [7:0]  RFC_CHAR_SEQ     = 8'h9c;
    localparam logic [7:0]  RFC_CODE_LOCAL   = 8'h01;
    localparam logic [7:0]  RFC_CODE_REMOTE  = 8'h02;
    localparam logic [7:0]  RFC_CHAR_ZERO    = 8'h00;
    localparam logic [3:0]  RFC_SEQ_COL_CTRL = 4'h1;
    localparam logic [7:0]  RFC_IDLE_CTRL    = 8'hff;
    localparam logic [63:0] RFC_IDLE_WORD    = {8{RFC_CHAR_IDLE}};

    // Fault detection: sequences needed and column window
    localparam logic [2:0] RFC_SEQ_NEEDED  = 3'h4;
    localparam logic [7:0] RFC_COL_WINDOW  = 8'h80;
    localparam logic [7:0] RFC_COLS_PER_WD = 8'h02;

    typedef enum logic [1:0] {
        RFC_FLT_NONE,
        RFC_FLT_LOCAL,
        RFC_FLT_REMOTE
    } rfc_fault_type;

    typedef enum logic [1:0] {
        RFC_TXM_DATA,
        RFC_TXM_LOCAL,
        RFC_TXM_REMOTE,
        RFC_TXM_IDLE
    } rfc_tx_mode_type;

    // Classify one 32-bit column as a fault sequence or not
    function automatic rfc_fault_type rfc_col_fault(input logic [31:0] d,
                                                    input logic [3:0]  c);
        rfc_fault_type f;
        f = RFC_FLT_NONE;
        if (c == RFC_SEQ_COL_CTRL && d[7:0] == RFC_CHAR_SEQ
            && d[23:8] == {RFC_CHAR_ZERO, RFC_CHAR_ZERO}) begin
            if (d[31:24] == RFC_CODE_LOCAL) begin
                f = RFC_FLT_LOCAL;
            end else if (d[31:24] == RFC_CODE_REMOTE) begin
                f = RFC_FLT_REMOTE;
            end
        end
        return f;
    endfunction : rfc_col_fault

    // Build one 64-bit word of two fault sequence columns
    function automatic logic [63:0] rfc_fault_word(input logic [7:0] code);
        logic [31:0] col;
        col = {code, RFC_CHAR_ZERO, RFC_CHAR_ZERO, RFC_CHAR_SEQ};
        return {col, col};
    endfunction : rfc_fault_word

endpackage : rfc_pkg

//--- rtl/rfc_rx_fault_mon.sv
// Receive fault monitor: tracks fault sequences arriving from the PCS.
// Assumes one 64-bit word (two columns) per clock from the receive PCS.
`timescale 1ns/1ps
`default_nettype none
module rfc_rx_fault_mon
    import rfc_pkg::*;
(
    // Clock and resets
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        srst_i,
    // Receive words from the PCS
    input  wire logic [63:0] rx_data_i,
    input  wire logic [7:0]  rx_ctrl_i,
    // Fault modes
    output logic             local_mode_o,
    output logic             remote_mode_o
);

    typedef struct packed {
        rfc_fault_type last_seq;
        logic [2:0]    seq_cnt;
        logic [7:0]    col_cnt;
        rfc_fault_type mode;
    } rfc_rx_state_type;

    rfc_rx_state_type st_ff;
    rfc_rx_state_type nxt_st;
    rfc_fault_type    lo_f;
    rfc_fault_type    hi_f;
    rfc_fault_type    word_f;

    // Pick the fault type seen in this word, upper column last
    always_comb begin
        lo_f   = rfc_col_fault(rx_data_i[31:0], rx_ctrl_i[3:0]);
        hi_f   = rfc_col_fault(rx_data_i[63:32], rx_ctrl_i[7:4]);
        word_f = (hi_f != RFC_FLT_NONE) ? hi_f : lo_f;
    end

    // Sequence counting and fault mode tracking
    always_comb begin
        nxt_st = st_ff;
        if (srst_i) begin
            nxt_st = '0;
        end else if (word_f != RFC_FLT_NONE) begin
            nxt_st.col_cnt = '0;
            if (word_f == st_ff.last_seq) begin
                if (st_ff.seq_cnt >= RFC_SEQ_NEEDED - 3'h1) begin
                    nxt_st.mode = word_f;
                end else begin
                    nxt_st.seq_cnt = st_ff.seq_cnt + 3'h1;
                end
            end else begin
                nxt_st.last_seq = word_f;
                nxt_st.seq_cnt  = 3'h1;
            end
        end else if (st_ff.col_cnt >= RFC_COL_WINDOW - RFC_COLS_PER_WD) begin
            nxt_st.col_cnt  = '0;
            nxt_st.seq_cnt  = '0;
            nxt_st.last_seq = RFC_FLT_NONE;
            nxt_st.mode     = RFC_FLT_NONE;
        end else begin
            nxt_st.col_cnt = st_ff.col_cnt + RFC_COLS_PER_WD;
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign local_mode_o  = (st_ff.mode == RFC_FLT_LOCAL);
    assign remote_mode_o = (st_ff.mode == RFC_FLT_REMOTE);

    // Synchronous reset empties both fault modes next cycle
    property p_srst;
        @(posedge clk_i) disable iff (rst_i)
        srst_i |=> (!local_mode_o && !remote_mode_o);
    endproperty
    a_srst: assert property (p_srst) else $error("rx reset left a fault mode");

    // A quiet window ends any fault mode
    property p_quiet_clear;
        @(posedge clk_i) disable iff (rst_i)
        (!srst_i && word_f == RFC_FLT_NONE && st_ff.mode != RFC_FLT_NONE
         && st_ff.col_cnt >= RFC_COL_WINDOW - RFC_COLS_PER_WD)
        |=> (!local_mode_o && !remote_mode_o);
    endproperty
    a_quiet_clear: assert property (p_quiet_clear) else $error("fault mode not cleared");

endmodule : rfc_rx_fault_mon
`default_nettype wire

//--- rtl/rfc_top.sv
// Reconciliation fault control: AHB-Lite registers, receive fault monitor,
// fault status synchronisers and the transmit word selector.
// Assumes one system clock, synchronous inputs and a single AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
module rfc_top
    import rfc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    // AHB-Lite slave
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic             HREADYOUT_O,
    output logic [31:0]      HRDATA_O,
    output logic             HRESP_O,
    // Receive side from the PCS
    input  wire logic        RX_RECON_SRESET_I,
    input  wire logic [63:0] RX_DATA_I,
    input  wire logic [7:0]  RX_CTRL_I,
    output logic             RX_LOCAL_FAULT_O,
    output logic             RX_REMOTE_FAULT_O,
    // Transmit side: MAC in, PCS out
    input  wire logic [63:0] TX_DATA_I,
    input  wire logic [7:0]  TX_CTRL_I,
    output logic [63:0]      TX_DATA_O,
    output logic [7:0]       TX_CTRL_O
);
    import rfc_pkg::*;

    typedef struct packed {
        logic            fault_en;
        logic            force_local;
        logic            force_remote;
        logic            force_idle;
        logic            wr_pend;
        logic [7:0]      wr_addr;
        logic            hready;
        logic [31:0]     hrdata;
        logic [1:0]      sync1;
        logic [1:0]      sync2;
        rfc_tx_mode_type tx_mode;
        logic [63:0]     tx_data;
        logic [7:0]      tx_ctrl;
    } rfc_top_state_type;

    rfc_top_state_type st_ff;
    rfc_top_state_type nxt_st;
    logic              rx_local_mode;
    logic              rx_remote_mode;
    logic              addr_phase;
    logic [31:0]       ctrl_word;
    logic [31:0]       stat_word;

    // Receive fault monitor
    rfc_rx_fault_mon u_rx_mon (
        .clk_i         (CLK_SYS_I),
        .rst_i         (RST_I),
        .srst_i        (RX_RECON_SRESET_I),
        .rx_data_i     (RX_DATA_I),
        .rx_ctrl_i     (RX_CTRL_I),
        .local_mode_o  (rx_local_mode),
        .remote_mode_o (rx_remote_mode)
    );

    assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[RFC_HTRANS_ACTIVE_BIT];

    // Next state: bus slave, synchronisers, transmit selection
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.hready = 1'b1;
        ctrl_word     = '0;
        stat_word     = '0;
        // Data phase of a write lands in the control register
        if (st_ff.wr_pend && st_ff.wr_addr == RFC_CTRL_OFFSET) begin
            nxt_st.fault_en     = HWDATA_I[RFC_CTRL_FAULT_EN_BIT];
            nxt_st.force_local  = HWDATA_I[RFC_CTRL_LOCAL_BIT];
            nxt_st.force_remote = HWDATA_I[RFC_CTRL_REMOTE_BIT];
            nxt_st.force_idle   = HWDATA_I[RFC_CTRL_IDLE_BIT];
        end
        // Read values, control taken after any write this cycle
        ctrl_word[RFC_CTRL_FAULT_EN_BIT]  = nxt_st.fault_en;
        ctrl_word[RFC_CTRL_LOCAL_BIT]     = nxt_st.force_local;
        ctrl_word[RFC_CTRL_REMOTE_BIT]    = nxt_st.force_remote;
        ctrl_word[RFC_CTRL_IDLE_BIT]      = nxt_st.force_idle;
        stat_word[RFC_STAT_RX_LOCAL_BIT]  = st_ff.sync2[0];
        stat_word[RFC_STAT_RX_REMOTE_BIT] = st_ff.sync2[1];
        stat_word[RFC_STAT_TX_MODE_LSB +: 2] = st_ff.tx_mode;
        // Address phase: capture write, or fetch read data
        nxt_st.wr_pend = addr_phase && HWRITE_I;
        nxt_st.wr_addr = HADDR_I[7:0];
        if (addr_phase && !HWRITE_I) begin
            case (HADDR_I[7:0])
                RFC_CTRL_OFFSET:   nxt_st.hrdata = ctrl_word;
                RFC_STATUS_OFFSET: nxt_st.hrdata = stat_word;
                default:           nxt_st.hrdata = '0;
            endcase
        end
        // Fault modes into the transmit logic through two flops
        nxt_st.sync1 = {rx_remote_mode, rx_local_mode};
        nxt_st.sync2 = st_ff.sync1;
        // Forced sends first, then fault response, then MAC data
        if (st_ff.force_local) begin
            nxt_st.tx_mode = RFC_TXM_LOCAL;
        end else if (st_ff.force_remote) begin
            nxt_st.tx_mode = RFC_TXM_REMOTE;
        end else if (st_ff.force_idle) begin
            nxt_st.tx_mode = RFC_TXM_IDLE;
        end else if (st_ff.fault_en && st_ff.sync2[0]) begin
            nxt_st.tx_mode = RFC_TXM_REMOTE;
        end else if (st_ff.fault_en && st_ff.sync2[1]) begin
            nxt_st.tx_mode = RFC_TXM_IDLE;
        end else begin
            nxt_st.tx_mode = RFC_TXM_DATA;
        end
        // Word put out toward the PCS
        case (nxt_st.tx_mode)
            RFC_TXM_LOCAL: begin
                nxt_st.tx_data = rfc_fault_word(RFC_CODE_LOCAL);
                nxt_st.tx_ctrl = {RFC_SEQ_COL_CTRL, RFC_SEQ_COL_CTRL};
            end
            RFC_TXM_REMOTE: begin
                nxt_st.tx_data = rfc_fault_word(RFC_CODE_REMOTE);
                nxt_st.tx_ctrl = {RFC_SEQ_COL_CTRL, RFC_SEQ_COL_CTRL};
            end
            RFC_TXM_IDLE: begin
                nxt_st.tx_data = RFC_IDLE_WORD;
                nxt_st.tx_ctrl = RFC_IDLE_CTRL;
            end
            default: begin
                nxt_st.tx_data = TX_DATA_I;
                nxt_st.tx_ctrl = TX_CTRL_I;
            end
        endcase
    end

    // State register, idles toward the PCS during reset
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            st_ff              <= '0;
            st_ff.fault_en     <= RFC_CTRL_RESET[RFC_CTRL_FAULT_EN_BIT];
            st_ff.force_local  <= RFC_CTRL_RESET[RFC_CTRL_LOCAL_BIT];
            st_ff.force_remote <= RFC_CTRL_RESET[RFC_CTRL_REMOTE_BIT];
            st_ff.force_idle   <= RFC_CTRL_RESET[RFC_CTRL_IDLE_BIT];
            st_ff.hready       <= 1'b1;
            st_ff.tx_mode      <= RFC_TXM_IDLE;
            st_ff.tx_data      <= RFC_IDLE_WORD;
            st_ff.tx_ctrl      <= RFC_IDLE_CTRL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops, except HRESP_O tied low
    assign HREADYOUT_O       = st_ff.hready;
    assign HRDATA_O          = st_ff.hrdata;
    assign HRESP_O           = 1'b0;
    assign RX_LOCAL_FAULT_O  = st_ff.sync2[0];
    assign RX_REMOTE_FAULT_O = st_ff.sync2[1];
    assign TX_DATA_O         = st_ff.tx_data;
    assign TX_CTRL_O         = st_ff.tx_ctrl;

    // Forced local fault wins over everything
    property p_force_local;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        st_ff.force_local |=> (TX_DATA_O == rfc_fault_word(RFC_CODE_LOCAL)
                               && TX_CTRL_O == {RFC_SEQ_COL_CTRL, RFC_SEQ_COL_CTRL});
    endproperty
    a_force_local: assert property (p_force_local) else $error("local fault not sent");

    // Forced remote fault when local is not forced
    property p_force_remote;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        (!st_ff.force_local && st_ff.force_remote)
        |=> (TX_DATA_O == rfc_fault_word(RFC_CODE_REMOTE));
    endproperty
    a_force_remote: assert property (p_force_remote) else $error("remote fault not sent");

    // Forced idle replaces frame traffic
    property p_force_idle;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        (!st_ff.force_local && !st_ff.force_remote && st_ff.force_idle)
        |=> (TX_DATA_O == RFC_IDLE_WORD && TX_CTRL_O == RFC_IDLE_CTRL);
    endproperty
    a_force_idle: assert property (p_force_idle) else $error("idle not forced");

    // With response off, MAC data passes regardless of faults
    // Sampled reset in the antecedent skips the edge that still saw reset
    property p_resp_off;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        (!RST_I && !st_ff.force_local && !st_ff.force_remote && !st_ff.force_idle
         && !st_ff.fault_en)
        |=> (TX_DATA_O == $past(TX_DATA_I) && TX_CTRL_O == $past(TX_CTRL_I));
    endproperty
    a_resp_off: assert property (p_resp_off) else $error("fault acted on while disabled");

    // Indications follow the receive modes two cycles late
    property p_sync;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        ##2 (RX_LOCAL_FAULT_O == $past(rx_local_mode, 2)
             && RX_REMOTE_FAULT_O == $past(rx_remote_mode, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("indication not two flops late");

    // Local fault received: remote fault returned
    property p_resp_local;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        (!st_ff.force_local && !st_ff.force_remote && !st_ff.force_idle
         && st_ff.fault_en && RX_LOCAL_FAULT_O)
        |=> (TX_DATA_O == rfc_fault_word(RFC_CODE_REMOTE));
    endproperty
    a_resp_local: assert property (p_resp_local) else $error("no answer to local fault");

    // Remote fault received: idles only
    property p_resp_remote;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        (!st_ff.force_local && !st_ff.force_remote && !st_ff.force_idle
         && st_ff.fault_en && !RX_LOCAL_FAULT_O && RX_REMOTE_FAULT_O)
        |=> (TX_DATA_O == RFC_IDLE_WORD);
    endproperty
    a_resp_remote: assert property (p_resp_remote) else $error("no answer to remote fault");

    // No fault and no force: traffic resumes, not at the reset edge
    property p_resume;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        (!RST_I && !st_ff.force_local && !st_ff.force_remote && !st_ff.force_idle
         && !RX_LOCAL_FAULT_O && !RX_REMOTE_FAULT_O)
        |=> (TX_DATA_O == $past(TX_DATA_I) && st_ff.tx_mode == RFC_TXM_DATA);
    endproperty
    a_resume: assert property (p_resume) else $error("traffic did not resume");

endmodule : rfc_top
`default_nettype wire

//--- verification/rfc_far_model.sv
// Far-side model: receive PCS words, MAC transmit words and receive reset.
// Assumes the bench changes its controls just after rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module rfc_far_model (
    // Clock and controls from the bench
    input  wire logic        clk_i,
    input  wire logic [1:0]  rx_kind_i,
    input  wire logic        core_rst_i,
    // Words and reset toward the block
    output logic [63:0]      rx_data_o,
    output logic [7:0]       rx_ctrl_o,
    output logic [63:0]      tx_data_o,
    output logic [7:0]       tx_ctrl_o,
    output logic             srst_o
);
    logic [31:0] cnt_ff;

    // Start from idle receive words and a known MAC pattern
    initial begin
        cnt_ff    = 32'h0;
        rx_data_o = {8{8'h07}};
        rx_ctrl_o = 8'hff;
        tx_data_o = 64'h0;
        tx_ctrl_o = 8'h00;
        srst_o    = 1'b0;
    end

    // MAC words change every cycle so a stale word never passes
    always @(posedge clk_i) begin
        cnt_ff    <= cnt_ff + 32'h1;
        srst_o    <= core_rst_i;
        tx_data_o <= {cnt_ff, ~cnt_ff};
        tx_ctrl_o <= 8'h00;
        case (rx_kind_i)
            2'h1: begin
                rx_data_o <= {2{32'h0100009c}};
                rx_ctrl_o <= 8'h11;
            end
            2'h2: begin
                rx_data_o <= {2{32'h0200009c}};
                rx_ctrl_o <= 8'h11;
            end
            default: begin
                rx_data_o <= {8{8'h07}};
                rx_ctrl_o <= 8'hff;
            end
        endcase
    end
endmodule : rfc_far_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the reconciliation fault control block.
// Assumes zero-wait AHB-Lite slave and the far-side model beside it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rfc_pkg::*;
    localparam logic [71:0] W_LOC  = {{2{32'h0100009c}}, 8'h11};
    localparam logic [71:0] W_REM  = {{2{32'h0200009c}}, 8'h11};
    localparam logic [71:0] W_IDLE = {{8{8'h07}}, 8'hff};
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [1:0]  rx_kind = 2'h0;
    logic        core_rst = 1'b0;
    wire logic        hready, hresp, srst, rx_loc, rx_rem;
    wire logic [31:0] hrdata;
    wire logic [63:0] rxd, txd_in, txd_out;
    wire logic [7:0]  rxc, txc_in, txc_out;
    int n_fail = 0;
    int checks = 0;
    int cyc    = 0;

    // Clock at 200 MHz
    always #2.5 clk_sys = ~clk_sys;

    rfc_far_model u_far (.clk_i(clk_sys), .rx_kind_i(rx_kind), .core_rst_i(core_rst),
        .rx_data_o(rxd), .rx_ctrl_o(rxc), .tx_data_o(txd_in), .tx_ctrl_o(txc_in),
        .srst_o(srst));

    rfc_top u_dut (.CLK_SYS_I(clk_sys), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HREADYOUT_O(hready), .HRDATA_O(hrdata), .HRESP_O(hresp),
        .RX_RECON_SRESET_I(srst), .RX_DATA_I(rxd), .RX_CTRL_I(rxc),
        .RX_LOCAL_FAULT_O(rx_loc), .RX_REMOTE_FAULT_O(rx_rem), .TX_DATA_I(txd_in),
        .TX_CTRL_I(txc_in), .TX_DATA_O(txd_out), .TX_CTRL_O(txc_out));

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp32

    task automatic cmp_tx(input logic [71:0] exp, input string what);
        checks++;
        if ({txd_out, txc_out} !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, {txd_out, txc_out}, exp);
        end
    endtask : cmp_tx

    // One AHB single transfer; request held until hready is sampled high
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        q = hrdata;
        cmp32({31'h0, hresp}, 32'h0, "response");
    endtask : ahb

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        cmp32(q, exp, what);
    endtask : rd

    // Write control, then let the two-edge control latency pass
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
        repeat (3) @(posedge clk_sys);
    endtask : wr

    // Output word must be the MAC word of the cycle before
    task automatic chk_mac(input string what);
        logic [71:0] v;
        @(negedge clk_sys);
        v = {txd_in, txc_in};
        @(negedge clk_sys);
        cmp_tx(v, what);
    endtask : chk_mac

    task automatic wait_ind(input logic rem, input logic val, output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while ((rem ? rx_rem : rx_loc) !== val && n < 100);
    endtask : wait_ind

    task automatic t_reset;
        @(negedge clk_sys);
        cmp_tx(W_IDLE, "idle in reset");
        cmp32({31'h0, hready}, 32'h1, "ready in reset");
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(RFC_CTRL_OFFSET, 32'h0, "ctrl reset");
        rd(RFC_STATUS_OFFSET, 32'h0, "status reset");
        wr(32'h10, 32'hf);
        wr(RFC_STATUS_OFFSET, 32'hff);
        rd(32'h10, 32'h0, "unmapped");
        rd(RFC_CTRL_OFFSET, 32'h0, "ctrl after stray writes");
        chk_mac("data after reset");
        $display("test reset done");
    endtask : t_reset

    // Force inputs in priority order, with mode shown in status
    task automatic t_force;
        logic [3:0]  cv [5] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h0};
        logic [71:0] ew [4] = '{W_LOC, W_LOC, W_REM, W_IDLE};
        logic [1:0]  em [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
        for (int i = 0; i < 4; i++) begin
            wr(RFC_CTRL_OFFSET, {28'h0, cv[i]});
            @(negedge clk_sys);
            cmp_tx(ew[i], "forced word");
            repeat (3) @(negedge clk_sys);
            cmp_tx(ew[i], "forced word held");
            rd(RFC_STATUS_OFFSET, {26'h0, em[i], 4'h0}, "forced mode");
            rd(RFC_CTRL_OFFSET, {28'h0, cv[i]}, "ctrl readback");
        end
        wr(RFC_CTRL_OFFSET, 32'h0);
        chk_mac("data after force");
        $display("test force done");
    endtask : t_force

    task automatic t_local;
        int n;
        rx_kind <= 2'h1;
        wait_ind(1'b0, 1'b1, n);
        cmp32(32'(n >= 6 && n < 100), 32'h1, "local rise delay");
        chk_mac("fault ignored when disabled");
        wr(RFC_CTRL_OFFSET, 32'h1);
        @(negedge clk_sys);
        cmp_tx(W_REM, "local response");
        rd(RFC_STATUS_OFFSET, 32'h21, "local status");
        rx_kind <= 2'h0;
        wait_ind(1'b0, 1'b0, n);
        cmp32(32'(n >= 60 && n < 100), 32'h1, "local clear delay");
        chk_mac("data after local clears");
        $display("test local done");
    endtask : t_local

    task automatic t_remote;
        int n;
        rx_kind <= 2'h2;
        wait_ind(1'b1, 1'b1, n);
        cmp32(32'(n >= 6 && n < 100), 32'h1, "remote rise delay");
        cmp32({31'h0, rx_loc}, 32'h0, "local stays low");
        // Response word follows the indication by one edge
        @(negedge clk_sys);
        cmp_tx(W_IDLE, "remote response");
        rd(RFC_STATUS_OFFSET, 32'h32, "remote status");
        @(posedge clk_sys);
        rx_kind  <= 2'h0;
        core_rst <= 1'b1;
        @(posedge clk_sys);
        core_rst <= 1'b0;
        wait_ind(1'b1, 1'b0, n);
        cmp32(32'(n <= 8), 32'h1, "sync reset clears");
        repeat (2) @(negedge clk_sys);
        chk_mac("data after sync reset");
        wr(RFC_CTRL_OFFSET, 32'h0);
        $display("test remote done");
    endtask : t_remote

    // Main sequence
    initial begin
        t_reset();
        t_force();
        t_local();
        t_remote();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
